// >>> gpd_far_side.sv
// Far-side model: external pins and the converter's trigger input.
// Assumes the bench commands pin levels and the converter's source choice.
`timescale 1ns/1ps
module gpd_far_side (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Commands from the bench
    input  wire logic [7:0] pin_drive,
    input  wire logic       src_sel,
    // Device side
    input  wire logic       converter_trigger,
    output logic      [7:0] pin_in,
    output int              conv_count
);
    ////////////////////////////////////////////////////////////////////////
    // Pads follow the commanded level a cycle later, unrelated to reset
    always_ff @(posedge pclk) begin
        pin_in <= pin_drive;
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter starts only when its source selects the pin trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_count <= 0;
        end else if (converter_trigger === 1'b1 && src_sel) begin
            conv_count <= conv_count + 1;
        end
    end
endmodule

// >>> gpd_pin_detect.sv
// One pin of the detector: pin synchroniser, filter, edge and status.
// Assumes the pin is asynchronous to pclk and config comes from pclk flops.
`timescale 1ns/1ps
module gpd_pin_detect (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and configuration
    input  wire logic pin_async,
    input  wire logic sense,
    input  wire logic both,
    input  wire logic pol,
    input  wire logic clr,
    // Detector state
    output logic      lvl,
    output logic      rise,
    output logic      fall,
    output logic      raw
);

    ////////////////////////////////////////////////////////////////////////
    logic             sy1;       // First stage, read only by sy2
    logic             sy2;       // Second stage
    logic             sy3;       // Third stage
    logic             next_lvl;  // Filtered level for next cycle
    logic             set;       // Trigger condition this cycle
    logic             next_raw;  // Status for next cycle

    // Accept a change once stages two and three agree
    assign next_lvl = (sy2 == sy3) ? sy3 : lvl;
    assign rise     = next_lvl & ~lvl;
    assign fall     = ~next_lvl & lvl;
    // Edge choice: both edges, else polarity picks one
    assign set      = both ? (rise | fall) : (pol ? rise : fall);
    // Level pins follow the level; edge pins latch, set beats clear
    assign next_raw = sense ? ~(next_lvl ^ pol) : (set | (raw & ~clr));

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser, filter and status flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1 <= 1'b0;
            sy2 <= 1'b0;
            sy3 <= 1'b0;
            lvl <= 1'b0;
            raw <= 1'b0;
        end else begin
            sy1 <= pin_async;
            sy2 <= sy1;
            sy3 <= sy2;
            lvl <= next_lvl;
            raw <= next_raw;
        end
    end

endmodule

// >>> gpd_pkg.sv
// Package for the per-pin interrupt detector of an eight-bit port.
// Assumes a 32-bit APB slave with byte offsets inside a 4 KB window.
package gpd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Port shape
    localparam int unsigned   GPD_PINS      = 8;      // Pins on the port
    localparam int unsigned   GPD_ADDR_W    = 12;     // Decoded address bits
    localparam int unsigned   GPD_DATA_W    = 32;     // APB data width
    localparam int unsigned   GPD_TRIG_BIT  = 4;      // Pin that feeds the converter

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0]   GPD_OFF_SENSE = 12'h404; // Sense select
    localparam logic [11:0]   GPD_OFF_BOTH  = 12'h408; // Both-edge select
    localparam logic [11:0]   GPD_OFF_POL   = 12'h40c; // Event polarity
    localparam logic [11:0]   GPD_OFF_MASK  = 12'h410; // Interrupt mask
    localparam logic [11:0]   GPD_OFF_RAW   = 12'h414; // Raw status
    localparam logic [11:0]   GPD_OFF_MSK_ST = 12'h418; // Masked status
    localparam logic [11:0]   GPD_OFF_CLEAR = 12'h41c; // Clear, write only

    ////////////////////////////////////////////////////////////////////////
    // Reset values of the writable fields
    localparam logic [7:0]    GPD_RST_SENSE = 8'h00;
    localparam logic [7:0]    GPD_RST_BOTH  = 8'h00;
    localparam logic [7:0]    GPD_RST_POL   = 8'h00;
    localparam logic [7:0]    GPD_RST_MASK  = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field layout: data in the low byte, upper bits read as zero
    localparam int unsigned   GPD_FIELD_LSB = 0;
    localparam int unsigned   GPD_FIELD_MSB = 7;
    localparam logic [23:0]   GPD_RSVD_RD   = 24'h000000; // Upper read value

endpackage

// >>> gpd_top.sv
// Interrupt detector of an eight-bit port with an APB register slave.
// Assumes APB master on pclk; pins arrive asynchronously.
`timescale 1ns/1ps
module gpd_top #(
    parameter int unsigned N_PINS   = gpd_pkg::GPD_PINS,
    parameter int unsigned TRIG_BIT = gpd_pkg::GPD_TRIG_BIT
) (
    // Clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // APB slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [gpd_pkg::GPD_ADDR_W-1:0]   paddr,
    input  wire logic [gpd_pkg::GPD_DATA_W-1:0]   pwdata,
    output logic      [gpd_pkg::GPD_DATA_W-1:0]   prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Port pins
    input  wire logic [N_PINS-1:0]                pin_in,
    // Interrupts and converter trigger
    output logic      [N_PINS-1:0]                pin_irq,
    output logic                                  combined_port_interrupt,
    output logic                                  converter_trigger
);
    import gpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [N_PINS-1:0]     sense_select;      // One: level, zero: edge
    logic [N_PINS-1:0]     both_edge_bits;    // Both-edge select
    logic [N_PINS-1:0]     polarity_bits;     // Event polarity
    logic [N_PINS-1:0]     mask_enable_bits;  // Interrupt mask
    logic [N_PINS-1:0]     raw_status_bits;   // Raw status from pins
    logic [N_PINS-1:0]     masked_status_bits; // Raw AND mask
    logic [N_PINS-1:0]     clear_bits;        // Clear pulse to pins
    logic [N_PINS-1:0]     lvl;               // Filtered pin levels
    logic [N_PINS-1:0]     rise;              // Rising edge this cycle
    logic [N_PINS-1:0]     fall;              // Falling edge this cycle
    logic                  trig_prev;         // Last masked trigger bit
    logic                  setup;             // APB setup cycle
    logic                  wr_en;             // Write takes effect
    logic                  hit_sense;         // Address decodes
    logic                  hit_both;
    logic                  hit_pol;
    logic                  hit_mask;
    logic                  hit_raw;
    logic                  hit_msk_st;
    logic                  hit_clear;
    logic                  hit_any;           // Any mapped offset
    logic [N_PINS-1:0]     wr_field;          // Written field bits
    logic [N_PINS-1:0]     rd_field;          // Selected read field
    logic [GPD_DATA_W-1:0] next_prdata;       // Read word for next cycle
    logic                  next_pready;
    logic                  next_trig;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and transfer qualifiers
    assign setup      = psel & ~penable;
    assign wr_en      = psel & penable & pready & pwrite;
    assign hit_sense  = (paddr == GPD_OFF_SENSE);
    assign hit_both   = (paddr == GPD_OFF_BOTH);
    assign hit_pol    = (paddr == GPD_OFF_POL);
    assign hit_mask   = (paddr == GPD_OFF_MASK);
    assign hit_raw    = (paddr == GPD_OFF_RAW);
    assign hit_msk_st = (paddr == GPD_OFF_MSK_ST);
    assign hit_clear  = (paddr == GPD_OFF_CLEAR);
    assign hit_any    = hit_sense | hit_both | hit_pol | hit_mask
                      | hit_raw | hit_msk_st | hit_clear;
    assign wr_field   = pwdata[N_PINS-1:0];

    // Masked status is raw gated by mask
    assign masked_status_bits = raw_status_bits & mask_enable_bits;

    // Clear pulse only for ones written to clear offset
    assign clear_bits = (wr_en && hit_clear) ? wr_field : '0;

    ////////////////////////////////////////////////////////////////////////
    // Read selection; clear offset reads as zero
    assign rd_field =
        hit_sense  ? sense_select :
        hit_both   ? both_edge_bits :
        hit_pol    ? polarity_bits :
        hit_mask   ? mask_enable_bits :
        hit_raw    ? raw_status_bits :
        hit_msk_st ? masked_status_bits :
        '0;
    // Reserved upper bits read as zero
    assign next_prdata = {GPD_RSVD_RD, rd_field};
    // Answer comes in the cycle after setup
    assign next_pready = setup;

    ////////////////////////////////////////////////////////////////////////
    // APB answer flops: data, ready and error set at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            // Capture read word and error flag on setup
            if (setup) begin
                prdata  <= next_prdata;
                pslverr <= ~hit_any;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable configuration; status offsets ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_select     <= GPD_RST_SENSE;
            both_edge_bits   <= GPD_RST_BOTH;
            polarity_bits    <= GPD_RST_POL;
            mask_enable_bits <= GPD_RST_MASK;
        end else if (wr_en) begin
            // Only the low field is stored
            if (hit_sense) begin
                sense_select <= wr_field;
            end
            if (hit_both) begin
                both_edge_bits <= wr_field;
            end
            if (hit_pol) begin
                polarity_bits <= wr_field;
            end
            if (hit_mask) begin
                mask_enable_bits <= wr_field;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One detector per pin
    genvar g;
    generate
        for (g = 0; g < N_PINS; g++) begin : g_pin
            gpd_pin_detect u_det (
                .pclk      (pclk),
                .presetn   (presetn),
                .pin_async (pin_in[g]),
                .sense     (sense_select[g]),
                .both      (both_edge_bits[g]),
                .pol       (polarity_bits[g]),
                .clr       (clear_bits[g]),
                .lvl       (lvl[g]),
                .rise      (rise[g]),
                .fall      (fall[g]),
                .raw       (raw_status_bits[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Trigger pulse on each rise of the masked trigger pin status
    assign next_trig = masked_status_bits[TRIG_BIT] & ~trig_prev;

    // Interrupt outputs, registered from masked status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_irq                 <= '0;
            combined_port_interrupt <= 1'b0;
            converter_trigger       <= 1'b0;
            trig_prev               <= 1'b0;
        end else begin
            pin_irq                 <= masked_status_bits;
            combined_port_interrupt <= |masked_status_bits;
            converter_trigger       <= next_trig;
            trig_prev               <= masked_status_bits[TRIG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertion helpers
    logic [N_PINS-1:0] chk_set;   // Edge trigger per configuration
    logic [N_PINS-1:0] chk_lvl;   // Active level per polarity
    assign chk_set = (both_edge_bits & (rise | fall))
                   | (~both_edge_bits & ((polarity_bits & rise)
                   | (~polarity_bits & fall)));
    assign chk_lvl = ~((lvl ^ rise ^ fall) ^ polarity_bits);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Clear write and read access, as named steps
    sequence s_clear_write;
        wr_en && hit_clear;
    endsequence
    sequence s_setup_read;
        setup && !pwrite;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Both-edge pins latch every edge
    property p_both_edges;
        |(~sense_select & both_edge_bits & (rise | fall))
        |=> ((raw_status_bits & $past(~sense_select & both_edge_bits
             & (rise | fall))) == $past(~sense_select & both_edge_bits
             & (rise | fall)));
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("both-edge pin missed an edge");

    // Single edge chosen by polarity latches
    property p_single_edge;
        |(~sense_select & ~both_edge_bits & chk_set)
        |=> ((raw_status_bits & $past(~sense_select & ~both_edge_bits
             & chk_set)) == $past(~sense_select & ~both_edge_bits & chk_set));
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("polarity-selected edge not latched");

    // Wrong edge never raises a clear edge pin
    property p_wrong_edge;
        |(~sense_select & ~both_edge_bits & ~raw_status_bits
          & ~chk_set & (rise | fall))
        |=> ((raw_status_bits & $past(~sense_select & ~both_edge_bits
             & ~raw_status_bits & ~chk_set & (rise | fall))) == '0);
    endproperty
    a_wrong_edge: assert property (p_wrong_edge)
        else $error("opposite edge raised status");

    // Level pins follow the active level next cycle
    property p_level_follow;
        ((raw_status_bits ^ $past(chk_lvl)) & $past(sense_select)) == '0;
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level pin status does not follow level");

    // Pin interrupts equal masked status one cycle on
    property p_pin_irq;
        ##1 pin_irq == $past(raw_status_bits & mask_enable_bits);
    endproperty
    a_pin_irq: assert property (p_pin_irq)
        else $error("pin interrupt differs from masked status");

    // Combined line is the OR of pin interrupts
    property p_combined;
        combined_port_interrupt == (|pin_irq);
    endproperty
    a_combined: assert property (p_combined)
        else $error("combined interrupt wrong");

    // Masked pins never interrupt
    property p_masked_off;
        ##1 (pin_irq & ~$past(mask_enable_bits)) == '0;
    endproperty
    a_masked_off: assert property (p_masked_off)
        else $error("masked pin raised interrupt");

    // Edge status rises only after a qualifying edge
    property p_raw_cause;
        ##1 ((raw_status_bits & ~$past(raw_status_bits)
             & ~$past(sense_select) & ~$past(chk_set)) == '0);
    endproperty
    a_raw_cause: assert property (p_raw_cause)
        else $error("edge status set without an edge");

    // Ones written to clear drop idle edge bits
    property p_clear_one;
        s_clear_write ##0 (|(wr_field & ~sense_select & ~chk_set))
        |=> ((raw_status_bits & $past(wr_field & ~sense_select
             & ~chk_set)) == '0);
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("clear write left edge status set");

    // Zeros written to clear keep edge bits
    property p_clear_zero;
        s_clear_write
        |=> ((~raw_status_bits & $past(raw_status_bits & ~wr_field
             & ~sense_select)) == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear zero disturbed status");

    // Trigger pulse follows the trigger pin becoming active
    property p_trigger;
        $rose(masked_status_bits[TRIG_BIT])
        |=> converter_trigger ##1 !converter_trigger;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("converter trigger pulse wrong");

    // Read word shows zero reserved bits on the answer
    property p_reserved;
        s_setup_read |=> pready && (prdata[31:8] == GPD_RSVD_RD);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved read bits not zero");

    ////////////////////////////////////////////////////////////////////////
    // Read path and level clear steps
    sequence s_read_raw;
        s_setup_read ##0 hit_raw;
    endsequence
    sequence s_read_masked;
        s_setup_read ##0 hit_msk_st;
    endsequence
    sequence s_clear_level;
        s_clear_write ##0 (|(wr_field & sense_select & chk_lvl));
    endsequence

    // Raw read word carries the unmasked status
    property p_raw_read;
        s_read_raw |=> (prdata[N_PINS-1:0] == $past(raw_status_bits));
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw status read wrong");

    // Masked read word is raw AND mask
    property p_masked_read;
        s_read_masked
        |=> (prdata[N_PINS-1:0] == $past(raw_status_bits & mask_enable_bits));
    endproperty
    a_masked_read: assert property (p_masked_read)
        else $error("masked status read wrong");

    // Clear leaves an active level pin set
    property p_clear_level;
        s_clear_level
        |=> ((~raw_status_bits & $past(wr_field & sense_select & chk_lvl)) == '0);
    endproperty
    a_clear_level: assert property (p_clear_level)
        else $error("clear dropped level status");

endmodule

// >>> tb_top.sv
// Self-checking bench for the port interrupt detector.
// Assumes the APB slave answers on its own; every wait is bounded.
`timescale 1ns/1ps
module tb_top;
    import gpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_in;
    logic [7:0]  pin_irq;
    logic [7:0]  pin_drive = 8'h00;
    logic        combined_port_interrupt;
    logic        converter_trigger;
    logic        src_sel   = 1'b0;
    int          conv_count;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic        er;
    logic [11:0] offs [7]  = '{12'h404, 12'h408, 12'h40c, 12'h410, 12'h414, 12'h418, 12'h41c};

    // Clock of 5 ns
    always #2.5 pclk = ~pclk;

    gpd_top #(.N_PINS(8), .TRIG_BIT(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_irq(pin_irq), .combined_port_interrupt(combined_port_interrupt),
        .converter_trigger(converter_trigger));

    gpd_far_side far (
        .pclk(pclk), .presetn(presetn), .pin_drive(pin_drive), .src_sel(src_sel),
        .converter_trigger(converter_trigger), .pin_in(pin_in), .conv_count(conv_count));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask

    // Set pins and let the synchroniser settle
    task automatic pins(input logic [7:0] v);
        pin_drive <= v;
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and read-only places
        for (int i = 0; i < 7; i++) begin
            rchk("reset value", offs[i], 32'h00000000);
        end
        chk("mapped error", 32'h00000000, {31'h0, er});
        apb(1'b0, 12'h420, 32'h00000000);
        chk("unmapped data", 32'h00000000, rd);
        chk("unmapped error", 32'h00000001, {31'h0, er});
        wr(GPD_OFF_RAW, 32'h000000ff);
        wr(GPD_OFF_MSK_ST, 32'h000000ff);
        rchk("raw", GPD_OFF_RAW, 32'h00000000);
        rchk("masked", GPD_OFF_MSK_ST, 32'h00000000);
        // Read back the writable fields
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 32'h000000a5 + i);
            rchk("readback", offs[i], 32'h000000a5 + i);
            wr(offs[i], 32'h00000000);
        end
        // Single edges chosen by polarity
        wr(GPD_OFF_MASK, 32'h000000ff);
        wr(GPD_OFF_POL, 32'h0000000f);
        wr(GPD_OFF_CLEAR, 32'h000000ff);
        rchk("clear reads", GPD_OFF_CLEAR, 32'h00000000);
        src_sel <= 1'b1;
        pins(8'hff);
        rchk("raw", GPD_OFF_RAW, 32'h0000000f);
        rchk("masked", GPD_OFF_MSK_ST, 32'h0000000f);
        chk("pin_irq", 32'h0000000f, {24'h0, pin_irq});
        chk("combined", 32'h00000001, {31'h0, combined_port_interrupt});
        wr(GPD_OFF_CLEAR, 32'h000000f0);
        rchk("raw", GPD_OFF_RAW, 32'h0000000f);
        wr(GPD_OFF_CLEAR, 32'h000000ff);
        rchk("raw", GPD_OFF_RAW, 32'h00000000);
        chk("conversions", 32'h0, conv_count);
        pins(8'h00);
        rchk("raw", GPD_OFF_RAW, 32'h000000f0);
        chk("conversions", 32'h1, conv_count);
        // Both edges, converter source off
        wr(GPD_OFF_BOTH, 32'h0000000f);
        wr(GPD_OFF_CLEAR, 32'h000000ff);
        src_sel <= 1'b0;
        pins(8'hff);
        rchk("raw", GPD_OFF_RAW, 32'h0000000f);
        wr(GPD_OFF_CLEAR, 32'h000000ff);
        pins(8'h00);
        rchk("raw", GPD_OFF_RAW, 32'h000000ff);
        chk("conversions", 32'h1, conv_count);
        // Mask blocks outputs, detection continues
        wr(GPD_OFF_MASK, 32'h00000000);
        rchk("masked", GPD_OFF_MSK_ST, 32'h00000000);
        chk("pin_irq", 32'h00000000, {24'h0, pin_irq});
        chk("combined", 32'h00000000, {31'h0, combined_port_interrupt});
        rchk("raw", GPD_OFF_RAW, 32'h000000ff);
        wr(GPD_OFF_MASK, 32'h0000003c);
        rchk("masked", GPD_OFF_MSK_ST, 32'h0000003c);
        chk("pin_irq", 32'h0000003c, {24'h0, pin_irq});
        // Level sense: status equals pin matching polarity
        wr(GPD_OFF_SENSE, 32'h000000ff);
        wr(GPD_OFF_POL, 32'h000000aa);
        wr(GPD_OFF_BOTH, 32'h000000ff);
        pins(8'h0f);
        rchk("raw", GPD_OFF_RAW, 32'h0000005a);
        wr(GPD_OFF_CLEAR, 32'h000000ff);
        rchk("raw", GPD_OFF_RAW, 32'h0000005a);
        pins(8'haa);
        rchk("raw", GPD_OFF_RAW, 32'h000000ff);
        close_out();
    end
endmodule
